// File: verilog/fps_seq.sv
`timescale 1ns/10ps
module fps_seq
	import fps_pkg::*;
#(
	parameter int RES_MAX = RES_MAX_CYC,
	parameter int OSC_PERIOD = OSC_CYC,
	parameter int FIX_MAX = FIX_MAX_CYC,
	parameter int LEB = LEB_CYC,
	parameter int MEAS = MEAS_CYC
) (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// comparator results from the analog front end
	input wire fps_cmp_type cmp,
	// gate drive
	output logic gate_drive,
	// current sources
	output logic timing_src_en,
	output logic ss_src_en,
	output logic ss_src_limit,
	// status
	output logic prot_latched,
	output logic fixed_freq_conduction_mode,
	output logic switching_enabled,
	output logic mains_sample
);
	fps_cmp_type s;
	logic [CMP_W-1:0] s_bits;
	fps_state_type state;
	fps_state_type next_state;
	logic [CNT_W-1:0] osc_cnt;
	logic [CNT_W-1:0] on_cnt;
	logic armed;
	logic neg_seen;
	logic stop_now;
	logic start_ok;
	logic end_pulse;
	logic res_limit;
	logic meas_fault;
	logic halt_req;
	logic latch_set;
	logic next_gate;

	// analog results arrive unrelated to the clock
	fps_sync #(.W(CMP_W)) u_sync (
		.clock(clock),
		.nrst(nrst),
		.d(cmp),
		.q(s_bits)
	);
	assign s = fps_cmp_type'(s_bits);

	// oscillator; armed marks it high again until a stroke uses it
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			osc_cnt <= '0;
		end else if (osc_cnt >= CNT_W'(OSC_PERIOD - 1)) begin
			osc_cnt <= '0;
		end else begin
			osc_cnt <= osc_cnt + 1'b1;
		end
	end

	// a new period wins over the clear of the old one
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			armed <= 1'b0;
		end else if (osc_cnt >= CNT_W'(OSC_PERIOD - 1)) begin
			armed <= 1'b1;
		end else if (next_gate && !gate_drive) begin
			armed <= 1'b0;
		end
	end

	// mode is taken only while not switching, so it cannot change mid-stroke
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			fixed_freq_conduction_mode <= 1'b0;
		end else if (state == ST_LOCKOUT) begin
			fixed_freq_conduction_mode <= s.winding_sense_grounded;
		end
	end

	// on-time counter, zero in the first gate-high cycle
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			on_cnt <= '0;
		end else if (gate_drive && next_gate) begin
			on_cnt <= on_cnt + 1'b1;
		end else begin
			on_cnt <= '0;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			neg_seen <= 1'b0;
		end else if (!gate_drive) begin
			neg_seen <= 1'b0;
		end else if (s.winding_sense_negative) begin
			neg_seen <= 1'b1;
		end
	end

	// faults and latch
	assign latch_set = s.prot_above_latch
		|| (s.prot_above_trip && !s.ctrl_below_reg)
		|| s.over_temp;

	// a set in the same cycle as the reset level wins
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			prot_latched <= 1'b0;
		end else if (latch_set) begin
			prot_latched <= 1'b1;
		end else if (s.vcc_below_reset) begin
			prot_latched <= 1'b0;
		end
	end

	// faults override blanking: a pulse may be cut short only by a stop
	assign stop_now = (state != ST_RUN)
		|| s.ctrl_open
		|| s.prot_above_trip
		|| prot_latched || latch_set
		|| s.vcc_below_lockout;

	// the limit holds every resonant stroke; a negative sense only confirms it
	assign res_limit = !fixed_freq_conduction_mode && (on_cnt >= CNT_W'(RES_MAX - 1));

	assign end_pulse = (s.peak_current && on_cnt >= CNT_W'(LEB - 1))
		|| (fixed_freq_conduction_mode && on_cnt >= CNT_W'(FIX_MAX - 1))
		|| res_limit;

	// brown-out only counts on strokes long enough to measure
	assign meas_fault = gate_drive && end_pulse && !fixed_freq_conduction_mode
		&& (on_cnt >= CNT_W'(MEAS - 1)) && s.mains_low;

	assign halt_req = (gate_drive && res_limit)
		|| meas_fault
		|| (s.prot_above_trip && s.ctrl_below_reg);

	assign start_ok = armed && !s.ctrl_level_low
		&& (fixed_freq_conduction_mode || (s.secondary_done && s.valley));

	always_comb begin
		if (stop_now) begin
			next_gate = 1'b0;
		end else if (gate_drive) begin
			next_gate = !end_pulse;
		end else begin
			next_gate = start_ok;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			gate_drive <= 1'b0;
		end else begin
			gate_drive <= next_gate;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			mains_sample <= 1'b0;
		end else begin
			mains_sample <= gate_drive && !next_gate && (on_cnt >= CNT_W'(MEAS - 1));
		end
	end

	// supply sequencing
	always_comb begin
		next_state = state;
		case (state)
			ST_LOCKOUT: begin
				if (s.vcc_above_start && !s.vcc_below_lockout && !prot_latched && !latch_set) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (s.vcc_below_lockout) begin
					next_state = ST_LOCKOUT;
				end else if (halt_req) begin
					next_state = ST_HALT;
				end
			end
			ST_HALT: begin
				if (s.vcc_below_lockout) begin
					next_state = ST_LOCKOUT;
				end
			end
			default: begin
				next_state = ST_LOCKOUT;
			end
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state <= ST_LOCKOUT;
		end else begin
			state <= next_state;
		end
	end

	// current source enables
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			timing_src_en <= 1'b0;
			ss_src_en <= 1'b0;
			ss_src_limit <= 1'b0;
			switching_enabled <= 1'b0;
		end else begin
			timing_src_en <= (state == ST_RUN) && s.ctrl_below_reg;
			ss_src_en <= (state == ST_LOCKOUT) && s.sense_below_ss;
			ss_src_limit <= (state == ST_LOCKOUT) && !s.sense_below_ss;
			switching_enabled <= (next_state == ST_RUN);
		end
	end

	property p_blank;
		@(posedge clock) disable iff (!nrst)
		gate_drive && !stop_now && (on_cnt < CNT_W'(LEB - 1)) |=> gate_drive;
	endproperty
	a_blank: assert property (p_blank) else $error("pulse ended inside blanking");

	property p_ocp;
		@(posedge clock) disable iff (!nrst)
		gate_drive && s.peak_current && (on_cnt >= CNT_W'(LEB - 1)) |=> !gate_drive;
	endproperty
	a_ocp: assert property (p_ocp) else $error("peak current did not end pulse");

	property p_ctrl_open;
		@(posedge clock) disable iff (!nrst)
		s.ctrl_open |=> !gate_drive;
	endproperty
	a_ctrl_open: assert property (p_ctrl_open) else $error("switching with open feedback");

	property p_trip;
		@(posedge clock) disable iff (!nrst)
		s.prot_above_trip |=> !gate_drive ##1 !gate_drive;
	endproperty
	a_trip: assert property (p_trip) else $error("switching after protection trip");

	property p_latch;
		@(posedge clock) disable iff (!nrst)
		s.prot_above_latch |=> prot_latched && !gate_drive;
	endproperty
	a_latch: assert property (p_latch) else $error("latch not set above latch level");

	property p_latch_hold;
		@(posedge clock) disable iff (!nrst)
		prot_latched && !s.vcc_below_reset |=> prot_latched;
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latch cleared without reset level");

	property p_fix_max;
		@(posedge clock) disable iff (!nrst)
		fixed_freq_conduction_mode && gate_drive |-> on_cnt < CNT_W'(FIX_MAX);
	endproperty
	a_fix_max: assert property (p_fix_max) else $error("duty limit exceeded");

	property p_res_fault;
		@(posedge clock) disable iff (!nrst)
		gate_drive && res_limit && !s.vcc_below_lockout && state == ST_RUN |=> !gate_drive && state == ST_HALT;
	endproperty
	a_res_fault: assert property (p_res_fault) else $error("long on-time did not halt");

	// a stroke that saw the negative sense never outlasts the resonant limit
	property p_neg_limit;
		@(posedge clock) disable iff (!nrst)
		gate_drive && neg_seen && !fixed_freq_conduction_mode |-> on_cnt < CNT_W'(RES_MAX);
	endproperty
	a_neg_limit: assert property (p_neg_limit) else $error("on-time past limit after negative sense");

	property p_lockout;
		@(posedge clock) disable iff (!nrst)
		s.vcc_below_lockout |=> state == ST_LOCKOUT && !gate_drive;
	endproperty
	a_lockout: assert property (p_lockout) else $error("no stop at supply lockout");

	property p_timing;
		@(posedge clock) disable iff (!nrst)
		timing_src_en |-> $past(s.ctrl_below_reg) && $past(state) == ST_RUN;
	endproperty
	a_timing: assert property (p_timing) else $error("timing source on in regulation");

	property p_one_on;
		@(posedge clock) disable iff (!nrst)
		$rose(gate_drive) |-> !armed || (osc_cnt == '0);
	endproperty
	a_one_on: assert property (p_one_on) else $error("second switch-on in one period");
endmodule : fps_seq

// File: verilog/fps_pkg.sv
package fps_pkg;
	// clock
	localparam int CLK_NS = 5;
	// turn-on blanking; its length is not fixed by the part, plain default
	localparam int LEB_NS = 300;
	localparam int LEB_CYC = (LEB_NS + CLK_NS - 1) / CLK_NS;
	// longest single on-time in valley-resonant mode
	localparam int RES_MAX_US = 25;
	localparam int RES_MAX_CYC = (RES_MAX_US * 1000) / CLK_NS;
	// least on-time for a mains-level measurement
	localparam int MEAS_US = 2;
	localparam int MEAS_CYC = (MEAS_US * 1000 + CLK_NS - 1) / CLK_NS;
	// oscillator period, plain default
	localparam int OSC_NS = 10000;
	localparam int OSC_CYC = OSC_NS / CLK_NS;
	// duty limit in fixed-frequency mode, percent
	localparam int DUTY_PCT = 70;
	localparam int FIX_MAX_CYC = (OSC_CYC * DUTY_PCT) / 100;
	localparam int CNT_W = 16;

	// digitised comparator results, one bit each
	typedef struct packed {
		logic vcc_above_start;
		logic vcc_below_lockout;
		logic vcc_below_reset;
		logic prot_above_trip;
		logic prot_above_latch;
		logic ctrl_below_reg;
		logic ctrl_open;
		logic ctrl_level_low;
		logic winding_sense_grounded;
		logic winding_sense_negative;
		logic secondary_done;
		logic valley;
		logic peak_current;
		logic sense_below_ss;
		logic over_temp;
		logic mains_low;
	} fps_cmp_type;

	localparam int CMP_W = $bits(fps_cmp_type);

	typedef enum logic [2:0] {
		ST_LOCKOUT = 3'b001,
		ST_RUN = 3'b010,
		ST_HALT = 3'b100
	} fps_state_type;
endpackage : fps_pkg

// File: verilog/fps_sync.sv
`timescale 1ns/10ps
module fps_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	// first stage is read by the second stage only
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : fps_sync

// File: dv/fps_plant.sv
`timescale 1ns/10ps
module fps_plant (
	// clock
	input wire logic clock,
	// gate and load
	input wire logic gate_drive,
	input wire logic [15:0] peak_at,
	// sensed levels
	output logic peak_current,
	output logic secondary_done,
	output logic valley,
	output logic [15:0] off_cnt
);
	logic [15:0] on_cnt;
	initial begin
		on_cnt = 16'h0;
		off_cnt = 16'h0;
	end
	// saturate so a long lockout never fakes a new demag
	always @(posedge clock) begin
		on_cnt <= gate_drive ? on_cnt + 16'h1 : 16'h0;
		off_cnt <= gate_drive ? 16'h0 : off_cnt + 16'(off_cnt != 16'hffff);
	end
	// late peak models a slow load
	assign peak_current = gate_drive && on_cnt >= peak_at;
	// demag takes ten cycles, ringing minimum every fourth
	assign secondary_done = !gate_drive && off_cnt >= 16'ha;
	assign valley = secondary_done && off_cnt[1:0] == 2'h0;
endmodule : fps_plant

// File: dv/flyback_protection_sequencer_test.sv
`timescale 1ns/10ps
module flyback_protection_sequencer_test;
	import fps_pkg::*;
	localparam int LEB_T = 6;
	localparam int FIX_T = 70;
	localparam int RES_T = 200;
	localparam int MEAS_T = 20;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	fps_cmp_type c = '0;
	fps_cmp_type cmp;
	logic gate_drive, timing_src_en, ss_src_en, ss_src_limit, prot_latched, ffm, switching_enabled, mains_sample;
	logic pk, sd, vl, lat;
	logic [15:0] peak_at = 16'h3e8;
	logic [15:0] off_cnt;
	int mismatches = 0;
	int check_count = 0;
	int exp_q[$];
	int width = 0;
	int hi;

	initial forever #2.5 clock = ~clock;

	always_comb begin
		cmp = c;
		cmp.peak_current = pk;
		cmp.secondary_done = sd;
		cmp.valley = vl;
	end

	fps_seq #(.RES_MAX(RES_T), .OSC_PERIOD(100), .FIX_MAX(FIX_T), .LEB(LEB_T), .MEAS(MEAS_T)) dut_u (
		.clock(clock), .nrst(nrst), .cmp(cmp), .gate_drive(gate_drive), .timing_src_en(timing_src_en),
		.ss_src_en(ss_src_en), .ss_src_limit(ss_src_limit), .prot_latched(prot_latched),
		.fixed_freq_conduction_mode(ffm), .switching_enabled(switching_enabled), .mains_sample(mains_sample));
	fps_plant plant_u (.clock(clock), .gate_drive(gate_drive), .peak_at(peak_at), .peak_current(pk),
		.secondary_done(sd), .valley(vl), .off_cnt(off_cnt));

	task automatic check(input logic [31:0] seen, input logic [31:0] expd);
		check_count++;
		if (seen !== expd) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, expd);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : tick

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run

	// width of each stroke that ends while a note waits, against the oldest note
	always @(posedge clock) begin
		width <= gate_drive ? width + 1 : 0;
		if (!gate_drive && width > 0 && exp_q.size() > 0) begin
			check(width, exp_q.pop_front());
			check(mains_sample, width >= MEAS_T);
		end
	end

	// two idle edges first, so the stroke just ended is not taken
	task automatic note(input int p, input int e);
		@(negedge gate_drive);
		tick(2);
		peak_at = p[15:0];
		exp_q.push_back(e);
		while (exp_q.size() > 0)
			tick(1);
	endtask : note

	task automatic quiet(input logic on);
		hi = 0;
		repeat (200) begin
			tick(1);
			hi += int'(gate_drive);
		end
		check(hi != 0, on);
	endtask : quiet

	task automatic power(input logic grounded);
		c.sense_below_ss = 1'b1;
		c.vcc_below_lockout = 1'b1;
		c.vcc_above_start = 1'b0;
		c.vcc_below_reset = 1'b1;
		tick(5);
		c.winding_sense_grounded = grounded;
		c.vcc_below_reset = 1'b0;
		c.vcc_below_lockout = 1'b0;
		tick(5);
		check(ss_src_en, 1'b1);
		c.vcc_above_start = 1'b1;
		tick(5);
		check(switching_enabled, 1'b1);
		check(ffm, grounded);
		check(ss_src_en, 1'b0);
	endtask : power

	initial begin
		void'($urandom(68719));
		tick(20);
		nrst = 1'b1;
		tick(1);
		check(gate_drive, 1'b0);
		c.sense_below_ss = 1'b1;
		tick(5);
		check(ss_src_en, 1'b1);
		check(ss_src_limit, 1'b0);
		c.sense_below_ss = 1'b0;
		tick(5);
		check(ss_src_limit, 1'b1);
		$display("test soft start done");
		power(1'b1);
		c.mains_low = 1'b1;
		repeat (8) begin
			hi = $urandom_range(80, 0);
			note(hi, hi + 3 < LEB_T ? LEB_T : (hi + 3 > FIX_T ? FIX_T : hi + 3));
		end
		check(switching_enabled, 1'b1);
		c.mains_low = 1'b0;
		$display("test stroke widths done");
		for (int i = 0; i < 2; i++) begin
			c.ctrl_open = i == 0;
			c.ctrl_level_low = i == 1;
			tick(80);
			quiet(1'b0);
			c.ctrl_open = 1'b0;
			c.ctrl_level_low = 1'b0;
			quiet(1'b1);
		end
		$display("test inhibit done");
		for (int k = 0; k < 4; k++) begin
			lat = k != 0;
			c.ctrl_below_reg = k == 0 || k == 2;
			tick(5);
			check(timing_src_en, c.ctrl_below_reg);
			@(posedge gate_drive);
			#1;
			c.prot_above_trip = k < 3;
			c.prot_above_latch = k == 2;
			c.over_temp = k == 3;
			tick(4);
			check(gate_drive, 1'b0);
			check(prot_latched, lat);
			c.prot_above_trip = 1'b0;
			c.prot_above_latch = 1'b0;
			c.over_temp = 1'b0;
			c.vcc_below_lockout = 1'b1;
			c.vcc_above_start = 1'b0;
			tick(5);
			c.vcc_below_lockout = 1'b0;
			c.vcc_above_start = 1'b1;
			tick(5);
			check(switching_enabled, !lat);
			c.vcc_below_reset = 1'b1;
			tick(5);
			check(prot_latched, 1'b0);
			c.vcc_below_reset = 1'b0;
			c.ctrl_below_reg = 1'b0;
			power(1'b1);
		end
		$display("test protection done");
		power(1'b0);
		note(40, 43);
		@(posedge gate_drive);
		#1;
		check(off_cnt >= 16'hd, 1'b1);
		check(off_cnt[1:0], 2'h3);
		c.winding_sense_negative = 1'b1;
		note(1000, RES_T);
		tick(5);
		check(switching_enabled, 1'b0);
		$display("test valley mode done");
		complete_run();
	end

	initial begin
		tick(20000);
		mismatches++;
		$display("watchdog expired");
		complete_run();
	end
endmodule : flyback_protection_sequencer_test
